// File: core/iva_alloc.sv
// Purpose: Map interrupt causes to vector number, table offset, address
// Assumes: Request lines are synchronous to mclk_i
// Notes:   Lowest pending hardware number wins, traps last; no level arbitration is done here
//          Outputs are recomputed every cycle; nothing is held between requests
//          Level value of the delayed cause comes from the last level input
//          Trap numbers pass through unchecked; software keeps them legal
//          Reset outputs show the reset vector at the default table base
//
// Overview of operation
// - Vector for number n sits at offset 0x3FC minus 4n; reset is number 0.
// - Undefined instruction raises number 14 at offset 0x3C4, no level register.
// - Delayed software cause is number 63 at offset 0x300, level register 47.
// - Converter request is number 34, level register 18, offset 0x374.
// - Numbers 66 to 255 are software traps only, no level register.
`default_nettype none
module iva_alloc (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        undef_instr_i,
   input  wire logic        nmi_i,
   input  wire logic [31:0] periph_req_i,
   input  wire logic        delayed_req_i,
   input  wire logic        trap_i,
   input  wire logic [7:0]  trap_num_i,
   input  wire logic [31:0] vector_table_base_i,
   input  wire logic [3:0]  interrupt_level_reg_i [32],
   output logic             valid_o,
   output logic [7:0]       vec_num_o,
   output logic [9:0]       vec_ofs_o,
   output logic [31:0]      vec_addr_o,
   output logic [31:0]      vec_default_o,
   output logic [5:0]       lvl_reg_o,
   output logic [3:0]       level_o,
   output logic             has_level_o
);
   logic        next_valid;
   logic [7:0]  next_num;
   logic [4:0]  per_idx;
   logic [9:0]  next_ofs;

   // Priority by number: fixed causes first, then the peripheral lines
   // Lowest set peripheral bit wins, so scan from the top down
   // Traps come last: a trap instruction cannot preempt hardware
   always_comb begin
      next_valid = 1'b1;
      next_num   = iva_pkg::NUM_RESET;
      per_idx    = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (periph_req_i[i]) begin
            per_idx = 5'(i);
         end
      end
      if (undef_instr_i) begin
         next_num = iva_pkg::NUM_UNDEF;
      end else if (nmi_i) begin
         next_num = iva_pkg::NUM_NMI;
      end else if (|periph_req_i) begin
         next_num = iva_pkg::NUM_LVL_FIRST + {3'h0, per_idx};
      end else if (delayed_req_i) begin
         next_num = iva_pkg::NUM_DELAYED;
      end else if (trap_i) begin
         // Trap may name any number, including the system pair 0x40/0x41
         next_num = trap_num_i;
      end else begin
         next_valid = 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         valid_o   <= 1'b0;
         vec_num_o <= iva_pkg::NUM_RESET;
      end else begin
         valid_o   <= next_valid;
         vec_num_o <= next_num;
      end
   end

   // Shared by all three address outputs so they cannot disagree
   always_comb begin
      next_ofs = iva_pkg::VEC_TOP_OFS - {next_num, 2'b00};
   end

   // Offset and addresses; reset state yields the reset vector
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         vec_ofs_o     <= iva_pkg::VEC_TOP_OFS;
         vec_addr_o    <= iva_pkg::TABLE_BASE_DEFAULT + {22'h0, iva_pkg::VEC_TOP_OFS};
         vec_default_o <= iva_pkg::TABLE_BASE_DEFAULT + {22'h0, iva_pkg::VEC_TOP_OFS};
      end else begin
         vec_ofs_o     <= next_ofs;
         vec_addr_o    <= vector_table_base_i + {22'h0, next_ofs};
         vec_default_o <= iva_pkg::TABLE_BASE_DEFAULT + {22'h0, next_ofs};
      end
   end

   // Level register selection
   // Register number 0x3F on lvl_reg_o means the cause has none
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         lvl_reg_o   <= iva_pkg::LVLREG_NONE;
         level_o     <= 4'h0;
         has_level_o <= 1'b0;
      end else if (next_num == iva_pkg::NUM_NMI) begin
         lvl_reg_o   <= iva_pkg::LVLREG_NONE;
         level_o     <= iva_pkg::LVL_NMI;
         has_level_o <= 1'b1;
      end else if (next_num >= iva_pkg::NUM_LVL_FIRST && next_num <= iva_pkg::NUM_LVL_LAST) begin
         lvl_reg_o   <= 6'(next_num - iva_pkg::NUM_LVL_FIRST);
         level_o     <= interrupt_level_reg_i[5'(next_num - iva_pkg::NUM_LVL_FIRST)];
         has_level_o <= 1'b1;
      end else if (next_num == iva_pkg::NUM_DELAYED) begin
         lvl_reg_o   <= iva_pkg::LVLREG_DELAYED;
         level_o     <= interrupt_level_reg_i[31];
         has_level_o <= 1'b1;
      end else begin
         // Reset, undefined instruction, traps other than 0x0F-0x2F and 0x3F: no level register
         lvl_reg_o   <= iva_pkg::LVLREG_NONE;
         level_o     <= 4'h0;
         has_level_o <= 1'b0;
      end
   end

   // Address arithmetic
   chk_ofs_formula: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      1'b1 |=> vec_ofs_o == 10'(10'h3FC - {vec_num_o, 2'b00}))
      else $error("offset not 0x3FC-4n");

   chk_addr_sum: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      1'b1 |=> vec_addr_o == $past(vector_table_base_i) + {22'h0, vec_ofs_o})
      else $error("vector address not base plus offset");

   chk_default_sum: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      1'b1 |-> vec_default_o == 32'h000FFC00 + {22'h0, vec_ofs_o})
      else $error("default address not default base plus offset");

   chk_reset_vec: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      vec_num_o == 8'h00 |-> vec_default_o == 32'h000FFFFC)
      else $error("reset default address wrong");

   // Request presence
   chk_valid_any: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (undef_instr_i || nmi_i || (|periph_req_i) || delayed_req_i || trap_i)
      |=> valid_o)
      else $error("request gave no valid vector");

   chk_idle_none: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !undef_instr_i && !nmi_i && periph_req_i == 32'h0 && !delayed_req_i && !trap_i
      |=> !valid_o && vec_num_o == 8'h00)
      else $error("idle cycle showed a vector");

   // Fixed causes
   chk_undef_num: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      undef_instr_i |=> vec_num_o == 8'h0E && vec_ofs_o == 10'h3C4 && !has_level_o)
      else $error("undefined instruction vector wrong");

   chk_nmi_num: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      nmi_i && !undef_instr_i |=> vec_num_o == 8'h0F && valid_o)
      else $error("non-maskable request number wrong");

   chk_nmi_level: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      vec_num_o == 8'h0F && valid_o |-> level_o == 4'hF && has_level_o)
      else $error("NMI level not 0xF");

   chk_nmi_over_periph: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      nmi_i && periph_req_i[0] && !undef_instr_i
      |=> vec_num_o == 8'h0F && lvl_reg_o == 6'h3F)
      else $error("peripheral line beat non-maskable request");

   // Peripheral lines and level registers
   chk_adc_route: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      periph_req_i[18] && periph_req_i[17:0] == 18'h0 && !undef_instr_i && !nmi_i
      |=> vec_num_o == 8'h22 && vec_ofs_o == 10'h374)
      else $error("converter request not routed to 34");

   chk_adc_map: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      vec_num_o == 8'h22 |-> lvl_reg_o == 6'h12 && vec_ofs_o == 10'h374)
      else $error("converter mapping wrong");

   chk_periph_low: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      periph_req_i[31] && periph_req_i[30:0] == 31'h0 && !undef_instr_i && !nmi_i
      |=> vec_num_o == 8'h2F && lvl_reg_o == 6'h1F)
      else $error("last peripheral line mapping wrong");

   chk_lvl_window: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      vec_num_o >= 8'h10 && vec_num_o <= 8'h2F
      |-> has_level_o && lvl_reg_o == 6'(vec_num_o - 8'h10))
      else $error("level register index wrong");

   chk_lvl_value: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      periph_req_i[0] && !undef_instr_i && !nmi_i
      |=> level_o == $past(interrupt_level_reg_i[0]) && lvl_reg_o == 6'h00)
      else $error("level value not from register 0");

   // Delayed cause and traps
   chk_delayed_num: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      delayed_req_i && periph_req_i == 32'h0 && !undef_instr_i && !nmi_i
      |=> vec_num_o == 8'h3F && vec_ofs_o == 10'h300)
      else $error("delayed cause number wrong");

   chk_delayed_lvl: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      vec_num_o == 8'h3F && valid_o |-> vec_ofs_o == 10'h300 && lvl_reg_o == 6'h2F)
      else $error("delayed cause mapping wrong");

   chk_trap_pass: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      trap_i && !delayed_req_i && periph_req_i == 32'h0 && !undef_instr_i && !nmi_i
      |=> vec_num_o == $past(trap_num_i) && valid_o)
      else $error("trap number not passed through");

   chk_trap_nolvl: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      vec_num_o >= 8'h42 |-> !has_level_o)
      else $error("trap has level register");

   chk_trap_ofs: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      vec_num_o >= 8'h42 |-> vec_ofs_o <= 10'h2F4)
      else $error("trap offset above 0x2F4");

   chk_nolvl_reserved: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      vec_num_o >= 8'h30 && vec_num_o <= 8'h3E |-> !has_level_o)
      else $error("reserved number given a level");

   chk_sys_pair: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (vec_num_o == 8'h40 || vec_num_o == 8'h41) |-> !has_level_o)
      else $error("system pair given a level");
endmodule : iva_alloc
`default_nettype wire

// File: pkg/iva_pkg.sv
// Purpose: Constants for the interrupt vector allocation block
// Assumes: 8-bit interrupt numbers, 10-bit table offsets, 4-bit levels
// Notes:   Offsets are byte offsets into the vector table
`default_nettype none
package iva_pkg;
   localparam logic [9:0]  VEC_TOP_OFS    = 10'h3FC;
   localparam logic [31:0] TABLE_BASE_DEFAULT = 32'h000FFC00;
   localparam logic [7:0]  NUM_RESET      = 8'h00;
   localparam logic [7:0]  NUM_UNDEF      = 8'h0E;
   localparam logic [7:0]  NUM_NMI        = 8'h0F;
   localparam logic [7:0]  NUM_LVL_FIRST  = 8'h10;
   localparam logic [7:0]  NUM_LVL_LAST   = 8'h2F;
   localparam logic [7:0]  NUM_ADC        = 8'h22;
   localparam logic [7:0]  NUM_DELAYED    = 8'h3F;
   localparam logic [7:0]  NUM_OS_FIRST   = 8'h40;
   localparam logic [7:0]  NUM_OS_LAST    = 8'h41;
   localparam logic [7:0]  NUM_TRAP_FIRST = 8'h42;
   localparam logic [5:0]  LVLREG_DELAYED = 6'h2F;
   localparam logic [5:0]  LVLREG_NONE    = 6'h3F;
   localparam logic [3:0]  LVL_NMI        = 4'hF;
   localparam int          NUM_HW_SRC     = 32;
endpackage : iva_pkg
`default_nettype wire

// File: tb/interrupt_vector_allocation_tb.sv
// Purpose: Self-checking bench for the vector allocation block
// Assumes: Outputs follow requests one cycle later
// Notes: Numbers 0x40 and 0x41 are never requested
`default_nettype none
module interrupt_vector_allocation_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i = 0, rst_n_i = 0, undef_instr_i = 0, nmi_i = 0, delayed_req_i = 0, trap_i = 0;
   logic [31:0] periph_req_i = '0, vector_table_base_i, vec_addr_o, vec_default_o, fetch;
   logic [7:0]  trap_num_i = '0, vec_num_o;
   logic [3:0]  interrupt_level_reg_i [32], level_o;
   logic [9:0]  vec_ofs_o;
   logic [5:0]  lvl_reg_o;
   logic        valid_o, has_level_o;
   int          err_total = 0, n_tests = 0;
   always #5 mclk_i = ~mclk_i;
   initial for (int k = 0; k < 32; k++) interrupt_level_reg_i[k] = 4'(k ^ 5);
   iva_alloc uut (.mclk_i, .rst_n_i, .undef_instr_i, .nmi_i, .periph_req_i, .delayed_req_i,
      .trap_i, .trap_num_i, .vector_table_base_i, .interrupt_level_reg_i, .valid_o,
      .vec_num_o, .vec_ofs_o, .vec_addr_o, .vec_default_o, .lvl_reg_o, .level_o, .has_level_o);
   iva_core_model core (.mclk_i, .valid_i(valid_o), .vec_addr_i(vec_addr_o),
      .base_o(vector_table_base_i), .fetch_o(fetch));
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Level is judged only where one applies; has_level is checked on every call
   task automatic fire(string name, logic [7:0] n, logic [5:0] r, logic [3:0] l, logic h);
      logic [9:0] ofs;
      ofs = 10'h3FC - {n, 2'b00};
      repeat (2) @(posedge mclk_i);
      #1;
      check("valid", valid_o, 1);
      check("num", vec_num_o, n);
      check("ofs", vec_ofs_o, ofs);
      check("default", vec_default_o, 32'h000FFC00 + ofs);
      check("addr", vec_addr_o, vector_table_base_i + ofs);
      check("lvl_reg", lvl_reg_o, r);
      if (h) check("level", level_o, l);
      check("has_level", has_level_o, h);
      @(posedge mclk_i);
      {undef_instr_i, nmi_i, delayed_req_i, trap_i, periph_req_i} <= '0;
      #1;
      check("fetch", fetch, vector_table_base_i + ofs);
      $display("done %s", name);
   endtask : fire
   task automatic t_adc;
      @(posedge mclk_i) periph_req_i <= 32'h40040000;
      fire("adc", 8'h22, 6'h12, interrupt_level_reg_i[18], 1);
   endtask : t_adc
   task automatic t_undef;
      @(posedge mclk_i) {undef_instr_i, nmi_i} <= 2'h3;
      fire("undef", 8'h0E, 6'h3F, 4'h0, 0);
   endtask : t_undef
   task automatic t_nmi;
      @(posedge mclk_i) {nmi_i, delayed_req_i} <= 2'h3;
      fire("nmi", 8'h0F, 6'h3F, 4'hF, 1);
   endtask : t_nmi
   task automatic t_delayed;
      @(posedge mclk_i) {delayed_req_i, trap_i, trap_num_i} <= {2'h3, 8'h42};
      fire("delayed", 8'h3F, 6'h2F, interrupt_level_reg_i[31], 1);
   endtask : t_delayed
   task automatic t_trap;
      for (int i = 0; i < 2; i++) begin
         @(posedge mclk_i) {trap_i, trap_num_i} <= {1'b1, i ? 8'hFF : 8'h42};
         fire("trap", i ? 8'hFF : 8'h42, 6'h3F, 4'h0, 0);
      end
   endtask : t_trap
   task automatic t_edges;
      for (int k = 0; k < 32; k += 31) begin
         @(posedge mclk_i) periph_req_i[k] <= 1'b1;
         fire("edge", 8'(16 + k), 6'(k), interrupt_level_reg_i[k], 1);
      end
   endtask : t_edges
   task automatic complete_run;
      $display("tests %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   initial begin
      repeat (10) @(posedge mclk_i);
      #1;
      check("idle valid", valid_o, 0);
      check("idle default", vec_default_o, 32'h000FFFFC);
      @(posedge mclk_i) rst_n_i <= 1'b1;
      t_adc();
      t_undef();
      t_nmi();
      t_delayed();
      t_trap();
      t_edges();
      complete_run();
   end
   initial begin
      #100us;
      err_total++;
      complete_run();
   end
endmodule : interrupt_vector_allocation_tb
`default_nettype wire

// File: tb/iva_core_model.sv
// Purpose: Core side model: supplies table base, fetches vectors
// Assumes: Fetch address is taken on each valid cycle
// Notes:   Base value is arbitrary but not the reset default
`default_nettype none
module iva_core_model #(
   parameter logic [31:0] BASE = 32'h00001000
) (
   input  wire logic        mclk_i,
   input  wire logic        valid_i,
   input  wire logic [31:0] vec_addr_i,
   output logic [31:0]      base_o,
   output logic [31:0]      fetch_o
);
   timeunit 1ns;
   timeprecision 1ns;
   assign base_o = BASE;
   always_ff @(posedge mclk_i) begin
      if (valid_i) fetch_o <= vec_addr_i;
   end
endmodule : iva_core_model
`default_nettype wire
